// ---- include/uart_rx_pkg.sv ----
// Constants, field layout and types for the receive status and interrupt block
package uart_rx_pkg;

    // What this block does
    // - Mode 11 raises the receive interrupt when a transfer leaves the FIFO holding 4 characters.
    // - Mode 10 raises the receive interrupt when a transfer leaves the FIFO holding 3 characters.
    // - With the upper mode bit at 0 every character moved into the FIFO raises the interrupt.
    // - Address detect keeps only characters with the ninth bit set and acts only in 9-bit format.
    // - The idle flag reads 1 while the receiver waits and 0 while it takes in a character.
    // - The parity error flag shows the parity status of the character at the FIFO head.
    // - The framing error flag shows the framing status of the character at the FIFO head.
    // - Overflow of the FIFO sets the overrun flag, which software may clear but never set.
    // - Clearing a set overrun flag empties the FIFO and returns the shift register to empty.
    // - The data available flag is 1 while the FIFO holds at least one unread character.
    // - Received characters are kept in a first-in first-out store four entries deep.
    // - Format 00 is 8 bits plain, 01 is 8 bits even parity, 10 is 8 bits odd parity, 11 is 9 bits.

    // ****************************************************************
    // Register bus
    // ****************************************************************
    localparam int              ADDR_W           = 4;
    localparam int              DATA_W           = 16;
    localparam logic [ADDR_W-1:0] ADDR_STATUS_CTRL = 4'h0;
    localparam logic [ADDR_W-1:0] ADDR_FORMAT      = 4'h1;
    localparam logic [ADDR_W-1:0] ADDR_RX_DATA     = 4'h2;
    localparam logic [ADDR_W-1:0] ADDR_IRQ_STATUS  = 4'h3;
    localparam logic [ADDR_W-1:0] ADDR_IRQ_MASK    = 4'h4;

    // ****************************************************************
    // Status, control and format field positions
    // ****************************************************************
    localparam int BIT_AVAIL    = 0;
    localparam int BIT_OVERRUN  = 1;
    localparam int BIT_FRAMING_ERR_FLAG     = 2;
    localparam int BIT_PARITY_ERR_FLAG     = 3;
    localparam int BIT_IDLE     = 4;
    localparam int BIT_ADDR_EN  = 5;
    localparam int BIT_MODE_LO  = 6;
    localparam int BIT_MODE_HI  = 7;
    localparam int BIT_FMT_LO   = 0;
    localparam int BIT_FMT_HI   = 1;

    // ****************************************************************
    // Modes, formats and levels
    // ****************************************************************
    localparam logic [1:0] MODE_FULL    = 2'h3;
    localparam logic [1:0] MODE_3Q      = 2'h2;
    localparam logic [1:0] MODE_RESET   = 2'h0;
    localparam logic [1:0] FMT_8_NONE   = 2'h0;
    localparam logic [1:0] FMT_8_EVEN   = 2'h1;
    localparam logic [1:0] FMT_8_ODD    = 2'h2;
    localparam logic [1:0] FMT_9_NONE   = 2'h3;
    localparam logic [1:0] FMT_RESET    = 2'h0;
    localparam int         FIFO_DEPTH   = 4;
    localparam int         LEVEL_3Q     = 3;
    localparam int         LEVEL_FULL   = 4;
    localparam int         BITS_8       = 8;
    localparam int         BITS_9       = 9;
    localparam int         ADDR_BIT     = 8;
    localparam int         MIN_CLKS_BIT = 4;

    // ****************************************************************
    // Interrupt status bits
    // ****************************************************************
    localparam int IRQ_W       = 3;
    localparam int IRQ_RX      = 0;
    localparam int IRQ_OVERRUN = 1;
    localparam int IRQ_ERROR   = 2;

    // ****************************************************************
    // Types
    // ****************************************************************
    typedef struct packed {
        logic       parity_err;
        logic       framing_err;
        logic [8:0] data;
    } rx_entry_type;

    typedef enum logic [4:0] {
        RX_IDLE   = 5'h01,
        RX_START  = 5'h02,
        RX_DATA   = 5'h04,
        RX_PARITY = 5'h08,
        RX_STOP   = 5'h10
    } rx_state_type;

endpackage : uart_rx_pkg

// ---- rtl/rx_fifo.sv ----
// Small first-in first-out store with flush and occupancy count
`timescale 1ns/1ps
module rx_fifo #(
    parameter int WIDTH = 11,
    parameter int DEPTH = 4
) (
    input  wire logic                       ref_clk_in,
    input  wire logic                       reset_in,
    input  wire logic                       flush_in,
    input  wire logic                       push_in,
    input  wire logic [WIDTH-1:0]           push_data_in,
    input  wire logic                       pop_in,
    output logic      [WIDTH-1:0]           head_data_out,
    output logic      [$clog2(DEPTH+1)-1:0] count_out,
    output logic                            full_out,
    output logic                            empty_out
);
    localparam int PTR_W = $clog2(DEPTH);
    localparam int CNT_W = $clog2(DEPTH+1);

    if (DEPTH < 2 || (1 << PTR_W) != DEPTH) begin : g_depth_check
        $error("rx_fifo depth must be a power of two of at least two");
    end

    logic [WIDTH-1:0] mem [DEPTH];
    logic [PTR_W-1:0] wr_ptr;
    logic [PTR_W-1:0] rd_ptr;
    logic [CNT_W-1:0] count;
    logic             do_push;
    logic             do_pop;

    assign full_out      = (count == CNT_W'(DEPTH));
    assign empty_out     = (count == '0);
    assign count_out     = count;
    assign head_data_out = mem[rd_ptr];
    // Full store refuses pushes even when a pop lands in the same cycle
    assign do_push       = push_in && !full_out;
    assign do_pop        = pop_in && !empty_out;

    always_ff @(posedge ref_clk_in) begin
        if (do_push && !flush_in) begin
            mem[wr_ptr] <= push_data_in;
        end
    end

    always_ff @(posedge ref_clk_in) begin
        if (reset_in || flush_in) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count  <= '0;
        end else begin
            if (do_push) begin
                wr_ptr <= wr_ptr + PTR_W'(1);
            end
            if (do_pop) begin
                rd_ptr <= rd_ptr + PTR_W'(1);
            end
            count <= count + CNT_W'(do_push) - CNT_W'(do_pop);
        end
    end

endmodule : rx_fifo

// ---- rtl/uart_receive_status_irq.sv ----
// Serial receiver with FIFO status, error flags, address detect and interrupts
`timescale 1ns/1ps
module uart_receive_status_irq #(
    parameter int CLKS_PER_BIT = 104
) (
    input  wire logic                          ref_clk_in,
    input  wire logic                          reset_in,
    input  wire logic                          rx_in,
    input  wire logic [uart_rx_pkg::ADDR_W-1:0] addr_in,
    input  wire logic [uart_rx_pkg::DATA_W-1:0] wr_data_in,
    input  wire logic                          wr_en_in,
    input  wire logic                          rd_en_in,
    output logic      [uart_rx_pkg::DATA_W-1:0] rd_data_out,
    output logic                               irq_out
);
    localparam int TICK_W = $clog2(CLKS_PER_BIT);
    localparam int CNT_W  = $clog2(uart_rx_pkg::FIFO_DEPTH + 1);
    localparam int ENT_W  = $bits(uart_rx_pkg::rx_entry_type);
    localparam logic [TICK_W-1:0] TICK_FULL = TICK_W'(CLKS_PER_BIT - 1);
    localparam logic [TICK_W-1:0] TICK_HALF = TICK_W'(CLKS_PER_BIT / 2 - 1);

    if (CLKS_PER_BIT < uart_rx_pkg::MIN_CLKS_BIT) begin : g_baud_check
        $error("CLKS_PER_BIT too small for mid-bit sampling");
    end

    // ****************************************************************
    // Address decode
    // ****************************************************************
    function automatic logic hit(
        input logic                          strobe,
        input logic [uart_rx_pkg::ADDR_W-1:0] addr,
        input logic [uart_rx_pkg::ADDR_W-1:0] offset
    );
        hit = strobe && (addr == offset);
    endfunction : hit

    logic wr_status;
    logic wr_format;
    logic wr_mask;
    logic rd_rx_data;
    logic rd_irq_status;

    assign wr_status     = hit(wr_en_in, addr_in, uart_rx_pkg::ADDR_STATUS_CTRL);
    assign wr_format     = hit(wr_en_in, addr_in, uart_rx_pkg::ADDR_FORMAT);
    assign wr_mask       = hit(wr_en_in, addr_in, uart_rx_pkg::ADDR_IRQ_MASK);
    assign rd_rx_data    = hit(rd_en_in, addr_in, uart_rx_pkg::ADDR_RX_DATA);
    assign rd_irq_status = hit(rd_en_in, addr_in, uart_rx_pkg::ADDR_IRQ_STATUS);

    // ****************************************************************
    // Line synchroniser
    // ****************************************************************
    logic rx_meta;
    logic rx_sync;

    always_ff @(posedge ref_clk_in) begin
        if (reset_in) begin
            rx_meta <= 1'b1;
            rx_sync <= 1'b1;
        end else begin
            rx_meta <= rx_in;
            rx_sync <= rx_meta;
        end
    end

    // ****************************************************************
    // Control registers
    // ****************************************************************
    logic [1:0]                   rx_irq_mode;
    logic                         addr_detect_en;
    logic [1:0]                   data_format_sel;
    logic [uart_rx_pkg::IRQ_W-1:0] irq_mask;

    always_ff @(posedge ref_clk_in) begin
        if (reset_in) begin
            rx_irq_mode    <= uart_rx_pkg::MODE_RESET;
            addr_detect_en <= 1'b0;
        end else if (wr_status) begin
            rx_irq_mode    <= wr_data_in[uart_rx_pkg::BIT_MODE_HI:uart_rx_pkg::BIT_MODE_LO];
            addr_detect_en <= wr_data_in[uart_rx_pkg::BIT_ADDR_EN];
        end
    end

    always_ff @(posedge ref_clk_in) begin
        if (reset_in) begin
            data_format_sel <= uart_rx_pkg::FMT_RESET;
        end else if (wr_format) begin
            data_format_sel <= wr_data_in[uart_rx_pkg::BIT_FMT_HI:uart_rx_pkg::BIT_FMT_LO];
        end
    end

    always_ff @(posedge ref_clk_in) begin
        if (reset_in) begin
            irq_mask <= '0;
        end else if (wr_mask) begin
            irq_mask <= wr_data_in[uart_rx_pkg::IRQ_W-1:0];
        end
    end

    // ****************************************************************
    // Format decode
    // ****************************************************************
    logic       parity_on;
    logic       parity_odd;
    logic       nine_bit;
    logic [3:0] last_bit;

    assign nine_bit   = (data_format_sel == uart_rx_pkg::FMT_9_NONE);
    assign parity_on  = (data_format_sel == uart_rx_pkg::FMT_8_EVEN) ||
                        (data_format_sel == uart_rx_pkg::FMT_8_ODD);
    assign parity_odd = (data_format_sel == uart_rx_pkg::FMT_8_ODD);
    assign last_bit   = nine_bit ? 4'(uart_rx_pkg::BITS_9 - 1) : 4'(uart_rx_pkg::BITS_8 - 1);

    // ****************************************************************
    // Receive shift register and frame sequencer
    // ****************************************************************
    uart_rx_pkg::rx_state_type rx_state;
    logic [TICK_W-1:0]         tick;
    logic [3:0]                bit_idx;
    logic [8:0]                rx_shift_reg;
    logic                      parity_bit;
    logic                      char_valid;
    logic                      char_framing_err_flag;
    logic                      char_parity_err_flag;
    logic                      flush;

    // Format changes mid-character take effect at once; software should change it while idle
    always_ff @(posedge ref_clk_in) begin
        if (reset_in || flush) begin
            rx_state     <= uart_rx_pkg::RX_IDLE;
            tick         <= '0;
            bit_idx      <= '0;
            rx_shift_reg <= '0;
            parity_bit   <= 1'b0;
            char_valid   <= 1'b0;
            char_framing_err_flag    <= 1'b0;
            char_parity_err_flag    <= 1'b0;
        end else begin
            char_valid <= 1'b0;
            case (rx_state)
                uart_rx_pkg::RX_IDLE: begin
                    if (!rx_sync) begin
                        rx_state <= uart_rx_pkg::RX_START;
                        tick     <= TICK_HALF;
                    end
                end
                uart_rx_pkg::RX_START: begin
                    if (tick != '0) begin
                        tick <= tick - TICK_W'(1);
                    end else if (!rx_sync) begin
                        rx_state     <= uart_rx_pkg::RX_DATA;
                        tick         <= TICK_FULL;
                        bit_idx      <= '0;
                        rx_shift_reg <= '0;
                    end else begin
                        // Glitch shorter than half a bit is not a start
                        rx_state <= uart_rx_pkg::RX_IDLE;
                    end
                end
                uart_rx_pkg::RX_DATA: begin
                    if (tick != '0) begin
                        tick <= tick - TICK_W'(1);
                    end else begin
                        tick                  <= TICK_FULL;
                        rx_shift_reg[bit_idx] <= rx_sync;
                        bit_idx               <= bit_idx + 4'h1;
                        if (bit_idx == last_bit) begin
                            rx_state <= parity_on ? uart_rx_pkg::RX_PARITY : uart_rx_pkg::RX_STOP;
                        end
                    end
                end
                uart_rx_pkg::RX_PARITY: begin
                    if (tick != '0) begin
                        tick <= tick - TICK_W'(1);
                    end else begin
                        tick       <= TICK_FULL;
                        parity_bit <= rx_sync;
                        rx_state   <= uart_rx_pkg::RX_STOP;
                    end
                end
                uart_rx_pkg::RX_STOP: begin
                    if (tick != '0) begin
                        tick <= tick - TICK_W'(1);
                    end else begin
                        char_valid <= 1'b1;
                        char_framing_err_flag  <= !rx_sync;
                        char_parity_err_flag  <= parity_on &&
                                      ((^rx_shift_reg[7:0]) ^ parity_bit ^ parity_odd);
                        rx_state   <= uart_rx_pkg::RX_IDLE;
                    end
                end
                default: begin
                    rx_state <= uart_rx_pkg::RX_IDLE;
                end
            endcase
        end
    end

    // ****************************************************************
    // Address filter and FIFO
    // ****************************************************************
    uart_rx_pkg::rx_entry_type new_entry;
    uart_rx_pkg::rx_entry_type head_entry;
    logic [ENT_W-1:0]          head_bits;
    logic [CNT_W-1:0]          fifo_count;
    logic                      fifo_full;
    logic                      fifo_empty;
    logic                      drop_char;
    logic                      accept;
    logic                      push;
    logic                      pop;
    logic [CNT_W-1:0]          next_level;

    assign drop_char = nine_bit && addr_detect_en && !rx_shift_reg[uart_rx_pkg::ADDR_BIT];
    assign accept    = char_valid && !drop_char;
    assign push      = accept && !fifo_full;
    assign pop       = rd_rx_data && !fifo_empty;

    assign new_entry.parity_err  = char_parity_err_flag;
    assign new_entry.framing_err = char_framing_err_flag;
    assign new_entry.data        = rx_shift_reg;
    assign head_entry            = uart_rx_pkg::rx_entry_type'(head_bits);

    rx_fifo #(
        .WIDTH (ENT_W),
        .DEPTH (uart_rx_pkg::FIFO_DEPTH)
    ) u_rx_fifo (
        .ref_clk_in    (ref_clk_in),
        .reset_in      (reset_in),
        .flush_in      (flush),
        .push_in       (push),
        .push_data_in  (new_entry),
        .pop_in        (pop),
        .head_data_out (head_bits),
        .count_out     (fifo_count),
        .full_out      (fifo_full),
        .empty_out     (fifo_empty)
    );

    // ****************************************************************
    // Overrun flag
    // ****************************************************************
    logic overrun_flag;
    logic overrun_event;
    logic overrun_clear;

    assign overrun_event = accept && fifo_full;
    assign overrun_clear = wr_status && !wr_data_in[uart_rx_pkg::BIT_OVERRUN] && overrun_flag;
    // A new overflow in the clearing cycle keeps the flag and skips the flush
    assign flush         = overrun_clear && !overrun_event;

    always_ff @(posedge ref_clk_in) begin
        if (reset_in) begin
            overrun_flag <= 1'b0;
        end else if (overrun_event) begin
            overrun_flag <= 1'b1;
        end else if (overrun_clear) begin
            overrun_flag <= 1'b0;
        end
    end

    // ****************************************************************
    // Receive interrupt level selection
    // ****************************************************************
    logic rx_event;
    logic err_event;

    // Level seen right after the transfer, with a same-cycle read counted
    assign next_level = fifo_count + CNT_W'(1) - CNT_W'(pop);
    always_comb begin
        rx_event = 1'b0;
        if (push) begin
            if (!rx_irq_mode[1]) begin
                rx_event = 1'b1;
            end else if (rx_irq_mode == uart_rx_pkg::MODE_3Q) begin
                rx_event = (next_level == CNT_W'(uart_rx_pkg::LEVEL_3Q));
            end else if (rx_irq_mode == uart_rx_pkg::MODE_FULL) begin
                rx_event = (next_level == CNT_W'(uart_rx_pkg::LEVEL_FULL));
            end
        end
    end
    assign err_event = push && (char_parity_err_flag || char_framing_err_flag);

    // ****************************************************************
    // Interrupt status, mask and output
    // ****************************************************************
    logic [uart_rx_pkg::IRQ_W-1:0] irq_status;
    logic [uart_rx_pkg::IRQ_W-1:0] irq_set;
    logic [uart_rx_pkg::IRQ_W-1:0] next_irq_status;

    always_comb begin
        irq_set                          = '0;
        irq_set[uart_rx_pkg::IRQ_RX]      = rx_event;
        irq_set[uart_rx_pkg::IRQ_OVERRUN] = overrun_event;
        irq_set[uart_rx_pkg::IRQ_ERROR]   = err_event;
        // Set wins over the clearing read
        next_irq_status = irq_set | (rd_irq_status ? '0 : irq_status);
    end

    always_ff @(posedge ref_clk_in) begin
        if (reset_in) begin
            irq_status <= '0;
            irq_out    <= 1'b0;
        end else begin
            irq_status <= next_irq_status;
            irq_out    <= |(next_irq_status & irq_mask);
        end
    end

    // ****************************************************************
    // Read data
    // ****************************************************************
    logic [uart_rx_pkg::DATA_W-1:0] rd_word;
    logic                          rx_data_avail;
    logic                          receiver_idle_flag;
    logic                          parity_err_flag;
    logic                          framing_err_flag;

    assign rx_data_avail      = !fifo_empty;
    assign receiver_idle_flag = (rx_state == uart_rx_pkg::RX_IDLE);
    assign parity_err_flag    = rx_data_avail && head_entry.parity_err;
    assign framing_err_flag   = rx_data_avail && head_entry.framing_err;

    always_comb begin
        rd_word = '0;
        if (addr_in == uart_rx_pkg::ADDR_STATUS_CTRL) begin
            rd_word[uart_rx_pkg::BIT_MODE_HI:uart_rx_pkg::BIT_MODE_LO] = rx_irq_mode;
            rd_word[uart_rx_pkg::BIT_ADDR_EN] = addr_detect_en;
            rd_word[uart_rx_pkg::BIT_IDLE]    = receiver_idle_flag;
            rd_word[uart_rx_pkg::BIT_PARITY_ERR_FLAG]    = parity_err_flag;
            rd_word[uart_rx_pkg::BIT_FRAMING_ERR_FLAG]    = framing_err_flag;
            rd_word[uart_rx_pkg::BIT_OVERRUN] = overrun_flag;
            rd_word[uart_rx_pkg::BIT_AVAIL]   = rx_data_avail;
        end else if (addr_in == uart_rx_pkg::ADDR_FORMAT) begin
            rd_word[uart_rx_pkg::BIT_FMT_HI:uart_rx_pkg::BIT_FMT_LO] = data_format_sel;
        end else if (addr_in == uart_rx_pkg::ADDR_RX_DATA) begin
            rd_word[uart_rx_pkg::ADDR_BIT:0] = rx_data_avail ? head_entry.data : '0;
        end else if (addr_in == uart_rx_pkg::ADDR_IRQ_STATUS) begin
            rd_word[uart_rx_pkg::IRQ_W-1:0] = irq_status;
        end else if (addr_in == uart_rx_pkg::ADDR_IRQ_MASK) begin
            rd_word[uart_rx_pkg::IRQ_W-1:0] = irq_mask;
        end
    end

    // Data stand only in the cycle after the strobe
    always_ff @(posedge ref_clk_in) begin
        if (reset_in) begin
            rd_data_out <= '0;
        end else begin
            rd_data_out <= rd_en_in ? rd_word : '0;
        end
    end

endmodule : uart_receive_status_irq

// ---- testbench/uart_rx_checker.sv ----
// Port assertions for the receive status block
`timescale 1ns/1ps
module uart_rx_checker #(parameter int CLKS_PER_BIT = 104) (
    input wire logic        ref_clk_in,
    input wire logic        reset_in,
    input wire logic        rx_in,
    input wire logic [3:0]  addr_in,
    input wire logic [15:0] wr_data_in,
    input wire logic        wr_en_in,
    input wire logic        rd_en_in,
    input wire logic [15:0] rd_data_out,
    input wire logic        irq_out
);
    default clocking @(posedge ref_clk_in); endclocking
    default disable iff (reset_in);
    wire rd0 = rd_en_in && addr_in == 4'h0;
    wire wr0 = wr_en_in && addr_in == 4'h0;
    a_read_gap: assert property (!$past(rd_en_in) |-> rd_data_out == 16'h0)
        else $error("data outside read");
    a_unmapped_read: assert property (rd_en_in && addr_in > 4'h4 |=> rd_data_out == 16'h0)
        else $error("unmapped read");
    a_status_top: assert property (rd0 |=> rd_data_out[15:8] == 8'h0)
        else $error("status top bits");
    a_empty_no_err: assert property (rd0 ##1 !rd_data_out[0] |-> rd_data_out[3:2] == 2'h0)
        else $error("error flag when empty");
    a_format_bits: assert property (rd_en_in && addr_in == 4'h1 |=> rd_data_out[15:2] == 14'h0)
        else $error("format top bits");
    a_char_bits: assert property (rd_en_in && addr_in == 4'h2 |=> rd_data_out[15:9] == 7'h0)
        else $error("char top bits");
    a_ctrl_keep: assert property (wr0 ##1 rd0 |=> rd_data_out[7:5] == $past(wr_data_in[7:5], 2))
        else $error("control bits lost");
    // Mask reaches the pin one cycle after the write lands
    a_mask_off: assert property (wr_en_in && addr_in == 4'h4 && wr_data_in[2:0] == 3'h0 |=> ##1 !irq_out)
        else $error("irq while masked");
    c_irq: cover property ($rose(irq_out));
    c_pop: cover property (rd_en_in && addr_in == 4'h2);
    c_ctrl: cover property (wr0 ##1 rd0);
endmodule : uart_rx_checker

// ---- testbench/serial_tx_model.sv ----
// Behavioural remote transmitter driving the receive line
`timescale 1ns/1ps
module serial_tx_model #(parameter int CLKS_PER_BIT = 4) (
    input  wire logic ref_clk_in,
    output logic      line_out
);
    initial line_out = 1'b1;
    // Fault bit 0 flips parity, bit 1 sends a low stop bit
    task automatic send(input logic [8:0] d, input logic [1:0] fmt, input logic [1:0] flt);
        int   n;
        logic b;
        n = (fmt == 2'h0) ? 9 : 10;
        for (int k = 0; k <= n; k++) begin
            if (k == 0) b = 1'b0;
            else if (k == n) b = ~flt[1];
            else if (k == 9 && fmt != 2'h3) b = ^d[7:0] ^ fmt[1] ^ flt[0];
            else b = d[k-1];
            line_out <= b;
            repeat (CLKS_PER_BIT) @(posedge ref_clk_in);
        end
        // Back to mark at once so a low stop bit is not taken for a start
        line_out <= 1'b1;
        repeat (6) @(posedge ref_clk_in);
    endtask : send
endmodule : serial_tx_model

// ---- testbench/testbench.sv ----
// Self-checking bench for the receive status and interrupt block
`timescale 1ns/1ps
module testbench;
    logic        ref_clk_in = 1'b0;
    logic        reset_in = 1'b1;
    logic        rx_in;
    logic [3:0]  addr_in = 4'h0;
    logic [15:0] wr_data_in = 16'h0;
    logic        wr_en_in = 1'b0;
    logic        rd_en_in = 1'b0;
    logic [15:0] rd_data_out;
    logic        irq_out;
    int          n_fail = 0;
    int          checks = 0;
    int          cycles = 0;
    always #2.5 ref_clk_in = ~ref_clk_in;
    uart_receive_status_irq #(.CLKS_PER_BIT(4)) u_dut (.ref_clk_in, .reset_in, .rx_in, .addr_in, .wr_data_in,
        .wr_en_in, .rd_en_in, .rd_data_out, .irq_out);
    serial_tx_model #(.CLKS_PER_BIT(4)) u_tx (.ref_clk_in, .line_out(rx_in));
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        addr_in <= a;
        wr_data_in <= d;
        wr_en_in <= 1'b1;
        @(posedge ref_clk_in);
        wr_en_in <= 1'b0;
    endtask : wr
    task automatic rd(input logic [3:0] a, input logic [15:0] e);
        addr_in <= a;
        rd_en_in <= 1'b1;
        @(posedge ref_clk_in);
        rd_en_in <= 1'b0;
        #1 check(rd_data_out, e);
        @(posedge ref_clk_in);
    endtask : rd
    task automatic irq(input logic e);
        #1 check({15'h0, irq_out}, {15'h0, e});
        @(posedge ref_clk_in);
    endtask : irq
    task automatic complete_run();
        $display("checks %0d mismatches %0d", checks, n_fail);
        if (n_fail == 0 && checks > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask : complete_run
    always @(posedge ref_clk_in) begin
        cycles <= cycles + 1;
        if (cycles == 4000) begin
            n_fail++;
            complete_run();
        end
    end
    initial begin
        repeat (12) @(posedge ref_clk_in);
        reset_in <= 1'b0;
        rd(4'h0, 16'h0010);
        rd(4'h9, 16'h0000);
        wr(4'h4, 16'h0000);
        fork
            u_tx.send(9'h05a, 2'h0, 2'h0);
            begin
                repeat (20) @(posedge ref_clk_in);
                rd(4'h0, 16'h0000);
            end
        join
        irq(1'b0);
        wr(4'h4, 16'h0001);
        rd(4'h4, 16'h0001);
        irq(1'b1);
        rd(4'h3, 16'h0001);
        rd(4'h0, 16'h0011);
        rd(4'h2, 16'h005a);
        irq(1'b0);
        $display("test 1 done");
        wr(4'h0, 16'h0080);
        u_tx.send(9'h011, 2'h0, 2'h0);
        u_tx.send(9'h022, 2'h0, 2'h0);
        rd(4'h3, 16'h0000);
        u_tx.send(9'h033, 2'h0, 2'h0);
        rd(4'h3, 16'h0001);
        wr(4'h0, 16'h00c0);
        u_tx.send(9'h044, 2'h0, 2'h0);
        rd(4'h3, 16'h0001);
        wr(4'h0, 16'h00c2);
        rd(4'h0, 16'h00d1);
        u_tx.send(9'h055, 2'h0, 2'h0);
        rd(4'h0, 16'h00d3);
        wr(4'h0, 16'h0000);
        rd(4'h0, 16'h0010);
        $display("test 2 done");
        wr(4'h1, 16'h0001);
        u_tx.send(9'h001, 2'h1, 2'h1);
        u_tx.send(9'h003, 2'h1, 2'h2);
        rd(4'h0, 16'h0019);
        rd(4'h3, 16'h0007);
        rd(4'h2, 16'h0001);
        rd(4'h0, 16'h0015);
        rd(4'h2, 16'h0003);
        wr(4'h1, 16'h0002);
        u_tx.send(9'h003, 2'h2, 2'h0);
        rd(4'h0, 16'h0011);
        rd(4'h2, 16'h0003);
        $display("test 3 done");
        wr(4'h1, 16'h0003);
        rd(4'h1, 16'h0003);
        wr(4'h0, 16'h0020);
        u_tx.send(9'h055, 2'h3, 2'h0);
        u_tx.send(9'h1a5, 2'h3, 2'h0);
        rd(4'h0, 16'h0031);
        rd(4'h2, 16'h01a5);
        $display("test 4 done");
        complete_run();
    end
endmodule : testbench
bind uart_receive_status_irq uart_rx_checker #(.CLKS_PER_BIT(CLKS_PER_BIT)) u_chk (.ref_clk_in, .reset_in, .rx_in,
    .addr_in, .wr_data_in, .wr_en_in, .rd_en_in, .rd_data_out, .irq_out);
